// ### hw/dpf_top.sv
// Functional notes
// - Each block stores 4,608 bits at 512x9 and 256x18; the 1kx4, 2kx2 and 4kx1 ratios use 4,096 of them.
// - Ports can be organised as 256x18, 512x9, 1kx4, 2kx2 or 4kx1.
// - Read and write ports run independently and may use different widths.
// - A built-in control unit turns the block into a synchronous fifo with no fabric logic.
// - In fifo operation the width, and with it the depth, is chosen by configuration.
// - The fifo drives empty, full and configurable almost-empty and almost-full flags.
// - The control unit keeps its own counters and makes the read and write pointers.
// - Several blocks can be cascaded into wider or deeper memories or fifos.
// - Contents can be preloaded through the user jtag access macro for use as rom.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
module dpf_top (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [dpf_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dpf_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dpf_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [dpf_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wr_en,
  input wire logic wr_chip_en,
  input wire logic [dpf_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [dpf_pkg::WORD_BITS-1:0] wr_data,
  input wire logic rd_en,
  input wire logic rd_chip_en,
  input wire logic [dpf_pkg::ADDR_W-1:0] rd_addr,
  output logic [dpf_pkg::WORD_BITS-1:0] rd_data,
  output logic rd_valid,
  input wire logic jtag_load_en,
  input wire logic [dpf_pkg::WADDR_W-1:0] jtag_load_addr,
  input wire logic [dpf_pkg::WORD_BITS-1:0] jtag_load_data,
  output logic empty,
  output logic full,
  output logic almost_empty_flag,
  output logic almost_full_flag,
  output logic irq
);
  import dpf_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic awready_reg, awready_next, wready_reg, wready_next, bvalid_reg, bvalid_next;
  logic arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [AXI_AW-1:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [CNT_W-1:0] ae_level_reg, ae_level_next, af_level_reg, af_level_next;
  logic [IRQ_N-1:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next, irq_event;
  logic irq_reg, irq_next, fifo_clr_reg, fifo_clr_next;
  logic aw_take, w_take, ar_take, do_wr;
  logic [AXI_AW-1:0] wr_reg_addr;
  logic [31:0] wr_reg_data, strb_mask, status_word;

  logic [ADDR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [CNT_W-1:0] count_reg, count_next, depth;
  logic empty_reg, empty_next, full_reg, full_next, ae_reg, ae_next, af_reg, af_next;
  logic fifo_mode, push, pop, wr_try, rd_try;
  dpf_width_t wr_width, rd_width;
  logic [WADDR_W+OFF_W-1:0] wmap, rmap;

  dpf_ram_if ram_bus ();

  dpf_ram u_ram (
    .ref_clk(ref_clk),
    .reset(reset),
    .port(ram_bus.ram)
  );

  // ----------------------------------------------------------------
  // axi4-lite slave and registers
  // ----------------------------------------------------------------
  always_comb begin
    aw_take = s_axi_awvalid & awready_reg;
    w_take = s_axi_wvalid & wready_reg;
    ar_take = s_axi_arvalid & arready_reg;
    wr_reg_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    wr_reg_data = w_held_reg ? w_data_reg : s_axi_wdata;
    strb_mask = w_held_reg ? {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}}
                           : {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    do_wr = (aw_held_reg | aw_take) & (w_held_reg | w_take) & ~bvalid_reg;
    status_word = '0;
    status_word[CNT_W-1:0] = count_reg;
    status_word[ST_EMPTY_BIT] = empty_reg;
    status_word[ST_FULL_BIT] = full_reg;
    status_word[ST_AE_BIT] = ae_reg;
    status_word[ST_AF_BIT] = af_reg;
    aw_held_next = aw_held_reg | aw_take;
    aw_addr_next = aw_take ? s_axi_awaddr : aw_addr_reg;
    w_held_next = w_held_reg | w_take;
    w_data_next = w_take ? s_axi_wdata : w_data_reg;
    w_strb_next = w_take ? s_axi_wstrb : w_strb_reg;
    bvalid_next = bvalid_reg & ~s_axi_bready;
    bresp_next = bresp_reg;
    ctrl_next = ctrl_reg;
    ae_level_next = ae_level_reg;
    af_level_next = af_level_reg;
    irq_mask_next = irq_mask_reg;
    fifo_clr_next = 1'b0;
    // hardware events win over a simultaneous write-one-to-clear
    irq_stat_next = irq_stat_reg | irq_event;
    if (do_wr) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      case (wr_reg_addr)
        REG_CTRL: begin
          ctrl_next = ((ctrl_reg & ~strb_mask) | (wr_reg_data & strb_mask)) & CTRL_KEEP;
          fifo_clr_next = wr_reg_data[CTRL_CLR_BIT] & strb_mask[CTRL_CLR_BIT];
        end
        REG_AE_LEVEL: ae_level_next = CNT_W'((ae_level_reg & ~strb_mask) | (wr_reg_data & strb_mask));
        REG_AF_LEVEL: af_level_next = CNT_W'((af_level_reg & ~strb_mask) | (wr_reg_data & strb_mask));
        REG_STATUS: bresp_next = RESP_OKAY;
        REG_IRQ_STAT: irq_stat_next = (irq_stat_reg & ~IRQ_N'(wr_reg_data & strb_mask)) | irq_event;
        REG_IRQ_MASK: irq_mask_next = IRQ_N'((irq_mask_reg & ~strb_mask) | (wr_reg_data & strb_mask));
        default: bresp_next = RESP_DECERR;
      endcase
    end
    awready_next = ~aw_held_next & ~bvalid_next;
    wready_next = ~w_held_next & ~bvalid_next;
    rvalid_next = rvalid_reg & ~s_axi_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_take) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: rdata_next = ctrl_reg;
        REG_AE_LEVEL: rdata_next = 32'(ae_level_reg);
        REG_AF_LEVEL: rdata_next = 32'(af_level_reg);
        REG_STATUS: rdata_next = status_word;
        REG_IRQ_STAT: rdata_next = 32'(irq_stat_reg);
        REG_IRQ_MASK: rdata_next = 32'(irq_mask_reg);
        default: begin
          rdata_next = '0;
          rresp_next = RESP_DECERR;
        end
      endcase
    end
    arready_next = ~rvalid_next;
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      ctrl_reg <= CTRL_RESET;
      ae_level_reg <= AE_RESET;
      af_level_reg <= AF_RESET;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg <= 1'b0;
      fifo_clr_reg <= 1'b0;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      ctrl_reg <= ctrl_next;
      ae_level_reg <= ae_level_next;
      af_level_reg <= af_level_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= irq_next;
      fifo_clr_reg <= fifo_clr_next;
    end
  end

  // ----------------------------------------------------------------
  // port steering and fifo control unit
  // ----------------------------------------------------------------
  always_comb begin
    fifo_mode = ctrl_reg[CTRL_FIFO_BIT];
    // fifo uses the write width on both ports, so depth follows it
    wr_width = dpf_width_t'(ctrl_reg[CTRL_WW_LSB +: 3]);
    rd_width = fifo_mode ? wr_width : dpf_width_t'(ctrl_reg[CTRL_RW_LSB +: 3]);
    depth = depth_of(wr_width);
    // chip enables let fabric decode select one block of a cascade
    wr_try = wr_en & wr_chip_en & ~jtag_load_en;
    rd_try = rd_en & rd_chip_en;
    push = fifo_mode & wr_try & ~full_reg;
    pop = fifo_mode & rd_try & ~empty_reg;
    wr_ptr_next = push ? ADDR_W'((wr_ptr_reg + 12'h001) & (depth - 13'h0001)) : wr_ptr_reg;
    rd_ptr_next = pop ? ADDR_W'((rd_ptr_reg + 12'h001) & (depth - 13'h0001)) : rd_ptr_reg;
    count_next = CNT_W'(count_reg + {12'h000, push} - {12'h000, pop});
    if (fifo_clr_reg) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next = '0;
    end
    empty_next = count_next == '0;
    full_next = count_next >= depth;
    ae_next = count_next <= ae_level_reg;
    af_next = count_next >= af_level_reg;
    irq_event = '0;
    irq_event[IRQ_FULL] = full_next & ~full_reg;
    irq_event[IRQ_EMPTY] = empty_next & ~empty_reg;
    irq_event[IRQ_AF] = af_next & ~af_reg;
    irq_event[IRQ_AE] = ae_next & ~ae_reg;
    irq_event[IRQ_OVER] = fifo_mode & wr_try & full_reg;
    irq_event[IRQ_UNDER] = fifo_mode & rd_try & empty_reg;
    wmap = map_addr(wr_width, fifo_mode ? wr_ptr_reg : wr_addr);
    rmap = map_addr(rd_width, fifo_mode ? rd_ptr_reg : rd_addr);
    // fifo drives the array ports itself
    ram_bus.we = fifo_mode ? push : wr_try;
    ram_bus.waddr = wmap[WADDR_W+OFF_W-1:OFF_W];
    ram_bus.woff = wmap[OFF_W-1:0];
    ram_bus.wmask = mask_of(wr_width);
    ram_bus.wdata = wr_data;
    // jtag preload takes the write port and writes whole words
    if (jtag_load_en) begin
      ram_bus.we = 1'b1;
      ram_bus.waddr = jtag_load_addr;
      ram_bus.woff = '0;
      ram_bus.wmask = mask_of(DPF_X18);
      ram_bus.wdata = jtag_load_data;
    end
    ram_bus.re = fifo_mode ? pop : rd_try;
    ram_bus.raddr = rmap[WADDR_W+OFF_W-1:OFF_W];
    ram_bus.roff = rmap[OFF_W-1:0];
    ram_bus.rmask = mask_of(rd_width);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      empty_reg <= 1'b1;
      full_reg <= 1'b0;
      ae_reg <= 1'b1;
      af_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      empty_reg <= empty_next;
      full_reg <= full_next;
      ae_reg <= ae_next;
      af_reg <= af_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign rd_data = ram_bus.rdata;
  assign rd_valid = ram_bus.rvalid;
  assign empty = empty_reg;
  assign full = full_reg;
  assign almost_empty_flag = ae_reg;
  assign almost_full_flag = af_reg;
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_full_write_drop: assert property (full_reg && fifo_mode && wr_try && !fifo_clr_reg |=>
    $stable(wr_ptr_reg) && $past(!ram_bus.we)) else $error("write accepted while full");
  a_empty_read_drop: assert property (empty_reg && fifo_mode && rd_try && !fifo_clr_reg |=>
    $stable(rd_ptr_reg)) else $error("read accepted while empty");
  a_count_step_up: assert property (push && !pop && !fifo_clr_reg |=> count_reg == $past(count_reg) + 13'h0001)
    else $error("count did not rise by one on write");
  a_ptr_in_range: assert property (wr_ptr_reg < depth && rd_ptr_reg < depth)
    else $error("pointer outside configured depth");
  // full is judged against the depth of the previous cycle, so skip the cycle after a width change
  a_empty_full_flags: assert property ((empty_reg == (count_reg == '0)) && ((full_reg == (count_reg >= depth)) ||
    $changed(ctrl_reg))) else $error("empty or full flag disagrees with count");
  a_almost_empty_lvl: assert property (!$changed(ae_level_reg) |-> ae_reg == (count_reg <= ae_level_reg))
    else $error("almost empty flag wrong");
  a_almost_full_lvl: assert property (!$changed(af_level_reg) |-> af_reg == (count_reg >= af_level_reg))
    else $error("almost full flag wrong");
  a_fifo_read_data: assert property (pop |=> rd_valid)
    else $error("fifo read gave no data");
  a_jtag_word_write: assert property (jtag_load_en |-> ram_bus.we && ram_bus.wmask == 18'h3FFFF)
    else $error("jtag preload did not write a whole word");
  a_irq_follows_mask: assert property (irq == |(irq_stat_reg & irq_mask_reg))
    else $error("interrupt line disagrees with status and mask");

endmodule // dpf_top

// ### hw/dpf_pkg.sv
package dpf_pkg;

  // ----------------------------------------------------------------
  // storage geometry
  // ----------------------------------------------------------------
  localparam int TOTAL_BITS = 4608;
  localparam int MEM_WORDS = 256;
  localparam int WORD_BITS = 18;
  localparam int WADDR_W = 8;
  localparam int OFF_W = 5;
  localparam int ADDR_W = 12;
  localparam int CNT_W = 13;
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;

  typedef enum logic [2:0] {DPF_X1, DPF_X2, DPF_X4, DPF_X9, DPF_X18} dpf_width_t;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_AE_LEVEL = 8'h04;
  localparam logic [7:0] REG_AF_LEVEL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;

  localparam int CTRL_FIFO_BIT = 0;
  localparam int CTRL_WW_LSB = 1;
  localparam int CTRL_RW_LSB = 4;
  localparam int CTRL_CLR_BIT = 7;
  localparam logic [31:0] CTRL_KEEP = 32'h0000_007F;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0049;
  localparam logic [CNT_W-1:0] AE_RESET = 13'h0010;
  localparam logic [CNT_W-1:0] AF_RESET = 13'h00F0;

  localparam int ST_EMPTY_BIT = 16;
  localparam int ST_FULL_BIT = 17;
  localparam int ST_AE_BIT = 18;
  localparam int ST_AF_BIT = 19;

  localparam int IRQ_N = 6;
  localparam int IRQ_FULL = 0;
  localparam int IRQ_EMPTY = 1;
  localparam int IRQ_AF = 2;
  localparam int IRQ_AE = 3;
  localparam int IRQ_OVER = 4;
  localparam int IRQ_UNDER = 5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // aspect ratio helpers
  // ----------------------------------------------------------------
  function automatic logic [WORD_BITS-1:0] mask_of(input dpf_width_t w);
    case (w)
      DPF_X1: mask_of = 18'h00001;
      DPF_X2: mask_of = 18'h00003;
      DPF_X4: mask_of = 18'h0000F;
      DPF_X9: mask_of = 18'h001FF;
      default: mask_of = 18'h3FFFF;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] depth_of(input dpf_width_t w);
    case (w)
      DPF_X1: depth_of = 13'h1000;
      DPF_X2: depth_of = 13'h0800;
      DPF_X4: depth_of = 13'h0400;
      DPF_X9: depth_of = 13'h0200;
      default: depth_of = 13'h0100;
    endcase
  endfunction

  // narrow ports pack into the 16 data bits of a word, x9/x18 use all 18,
  // so data written at one width reads back coherently at another of its group
  function automatic logic [WADDR_W+OFF_W-1:0] map_addr(input dpf_width_t w, input logic [ADDR_W-1:0] a);
    case (w)
      DPF_X1: map_addr = {a[11:4], 1'b0, a[3:0]};
      DPF_X2: map_addr = {a[10:3], 1'b0, a[2:0], 1'b0};
      DPF_X4: map_addr = {a[9:2], 1'b0, a[1:0], 2'b00};
      DPF_X9: map_addr = {a[8:1], a[0] ? 5'h09 : 5'h00};
      default: map_addr = {a[7:0], 5'h00};
    endcase
  endfunction

endpackage

// ### hw/dpf_ram_if.sv
interface dpf_ram_if;
  logic we;
  logic [7:0] waddr;
  logic [4:0] woff;
  logic [17:0] wmask;
  logic [17:0] wdata;
  logic re;
  logic [7:0] raddr;
  logic [4:0] roff;
  logic [17:0] rmask;
  logic [17:0] rdata;
  logic rvalid;
  modport ctrl (output we, waddr, woff, wmask, wdata, re, raddr, roff, rmask, input rdata, rvalid);
  modport ram (input we, waddr, woff, wmask, wdata, re, raddr, roff, rmask, output rdata, rvalid);
endinterface

// ### hw/dpf_ram.sv
module dpf_ram (
  input wire logic ref_clk,
  input wire logic reset,
  dpf_ram_if.ram port
);
  import dpf_pkg::*;

  // ----------------------------------------------------------------
  // storage array
  // ----------------------------------------------------------------
  logic [WORD_BITS-1:0] mem [MEM_WORDS];
  logic [WORD_BITS-1:0] word_next;
  logic [WORD_BITS-1:0] rdata_reg;
  logic [WORD_BITS-1:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  always_comb begin
    word_next = (mem[port.waddr] & ~18'(port.wmask << port.woff)) | 18'((port.wdata & port.wmask) << port.woff);
    rdata_next = port.re ? (18'(mem[port.raddr] >> port.roff) & port.rmask) : rdata_reg;
    rvalid_next = port.re;
  end

  // sram contents are not cleared by reset; a same-word read and write returns the old data
  always_ff @(posedge ref_clk) begin
    if (port.we) begin
      mem[port.waddr] <= word_next;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign port.rdata = rdata_reg;
  assign port.rvalid = rvalid_reg;

  a_read_one_cycle: assert property (@(posedge ref_clk) disable iff (reset)
    port.re |=> port.rvalid && port.rdata == (18'($past(mem[port.raddr]) >> $past(port.roff)) & $past(port.rmask)))
    else $error("read data not returned one cycle after request");

endmodule // dpf_ram

// ### bench/dpf_fabric_model.sv
module dpf_fabric_model import dpf_pkg::*; (
  input wire logic ref_clk,
  output logic wr_en,
  output logic wr_chip_en,
  output logic [dpf_pkg::ADDR_W-1:0] wr_addr,
  output logic [dpf_pkg::WORD_BITS-1:0] wr_data,
  output logic rd_en,
  output logic rd_chip_en,
  output logic [dpf_pkg::ADDR_W-1:0] rd_addr,
  output logic jtag_load_en,
  output logic [dpf_pkg::WADDR_W-1:0] jtag_load_addr,
  output logic [dpf_pkg::WORD_BITS-1:0] jtag_load_data,
  input wire logic [dpf_pkg::WORD_BITS-1:0] rd_data,
  input wire logic rd_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [WORD_BITS-1:0] last_rd;
  initial begin
    {wr_en, wr_chip_en, rd_en, rd_chip_en, jtag_load_en} = 5'h00;
    {wr_addr, rd_addr, wr_data, jtag_load_addr, jtag_load_data} = '0;
    last_rd = '0;
  end
  always @(posedge ref_clk) begin
    if (rd_valid) begin
      last_rd <= rd_data;
    end
  end
  // one port cycle, then the lines are released and inverted so stale data never looks valid
  task automatic op(input logic we, input logic re, input logic ce, input logic [11:0] wa, input logic [11:0] ra,
                    input logic [17:0] d);
    @(posedge ref_clk);
    {wr_en, rd_en, wr_chip_en, rd_chip_en} <= {we, re, ce, ce};
    {wr_addr, rd_addr, wr_data} <= {wa, ra, d};
    @(posedge ref_clk);
    {wr_en, rd_en, wr_chip_en, rd_chip_en} <= 4'h0;
    {wr_addr, rd_addr, wr_data} <= ~{wa, ra, d};
    @(posedge ref_clk);
    #1;
  endtask
  task automatic jtag(input logic [7:0] a, input logic [17:0] d);
    @(posedge ref_clk);
    {jtag_load_en, jtag_load_addr, jtag_load_data} <= {1'b1, a, d};
    @(posedge ref_clk);
    {jtag_load_en, jtag_load_addr, jtag_load_data} <= {1'b0, ~a, ~d};
    #1;
  endtask
endmodule // dpf_fabric_model

// ### bench/tb_top.sv
module tb_top import dpf_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, reset;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [AXI_DW-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic wr_en, wr_chip_en, rd_en, rd_chip_en, rd_valid, jtag_load_en;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [WORD_BITS-1:0] wr_data, rd_data, jtag_load_data;
  logic [WADDR_W-1:0] jtag_load_addr;
  logic empty, full, almost_empty_flag, almost_full_flag, irq;
  int failures, comparisons, cycles, n;
  int dep[5] = '{4096, 2048, 1024, 512, 256};
  int bits[5] = '{1, 2, 4, 9, 18};

  dpf_top i_dut (.ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wr_en, .wr_chip_en, .wr_addr,
    .wr_data, .rd_en, .rd_chip_en, .rd_addr, .rd_data, .rd_valid, .jtag_load_en, .jtag_load_addr,
    .jtag_load_data, .empty, .full, .almost_empty_flag, .almost_full_flag, .irq);
  dpf_fabric_model i_fab (.ref_clk, .wr_en, .wr_chip_en, .wr_addr, .wr_data, .rd_en, .rd_chip_en, .rd_addr,
    .jtag_load_en, .jtag_load_addr, .jtag_load_data, .rd_data, .rd_valid);

  // ----------------------------------------------------------------
  // clock, timeout, checking
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [17:0] pat(int i, int w);
    pat = 18'((i * 5 + w * 3 + 1) & ((1 << bits[w]) - 1));
  endfunction

  // ----------------------------------------------------------------
  // register bus master
  // ----------------------------------------------------------------
  // waits are bounded only by the global cycle ceiling
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge ref_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    failures = 0;
    comparisons = 0;
    cycles = 0;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    rchk(REG_CTRL, 32'h0000_0049, RESP_OKAY);
    rchk(REG_AE_LEVEL, 32'h0000_0010, RESP_OKAY);
    rchk(REG_AF_LEVEL, 32'h0000_00F0, RESP_OKAY);
    rchk(REG_STATUS, 32'h0005_0000, RESP_OKAY);
    rchk(REG_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
    rchk(8'h18, 32'h0000_0000, RESP_DECERR);
    axi_wr(8'h1C, 32'h0000_0001, resp);
    chk(resp, RESP_DECERR);
    // status is read only: a write is answered but changes nothing
    axi_wr(REG_STATUS, 32'h000F_1FFF, resp);
    chk(resp, RESP_OKAY);
    rchk(REG_STATUS, 32'h0005_0000, RESP_OKAY);
    // a write without chip select must not land
    i_fab.op(1'b1, 1'b0, 1'b0, 12'h000, 12'h000, 18'h3FFFF);
    chk(empty, 1'b1);
    for (int w = 0; w < 5; w++) begin
      axi_wr(REG_AE_LEVEL, 32'h0000_0002, resp);
      axi_wr(REG_AF_LEVEL, 32'(dep[w] - 2), resp);
      axi_wr(REG_CTRL, 32'h0000_0081 | 32'(w << 1) | 32'(w << 4), resp);
      chk(resp, RESP_OKAY);
      repeat (3) @(posedge ref_clk);
      chk(empty, 1'b1);
      for (int i = 0; i <= dep[w]; i++) begin
        i_fab.op(1'b1, 1'b0, 1'b1, 12'h000, 12'h000, pat(i, w));
        n = (i < dep[w]) ? i + 1 : dep[w];
        chk(full, 32'(n == dep[w]));
        chk(almost_empty_flag, 32'(n <= 2));
        chk(almost_full_flag, 32'(n >= dep[w] - 2));
      end
      rchk(REG_STATUS, 32'h000A_0000 | 32'(dep[w]), RESP_OKAY);
      for (int i = 0; i <= dep[w]; i++) begin
        i_fab.op(1'b0, 1'b1, 1'b1, 12'h000, 12'h000, 18'h00000);
        chk(i_fab.last_rd, pat((i < dep[w]) ? i : dep[w] - 1, w));
      end
      rchk(REG_STATUS, 32'h0005_0000, RESP_OKAY);
    end
    chk(irq, 1'b0);
    rchk(REG_IRQ_STAT, 32'h0000_003F, RESP_OKAY);
    axi_wr(REG_IRQ_MASK, 32'h0000_0030, resp);
    repeat (2) @(negedge ref_clk);
    chk(irq, 1'b1);
    axi_wr(REG_IRQ_STAT, 32'h0000_0030, resp);
    repeat (2) @(negedge ref_clk);
    chk(irq, 1'b0);
    rchk(REG_IRQ_STAT, 32'h0000_000F, RESP_OKAY);
    // memory mode: write one x4 nibble, read it back as four x1 bits
    axi_wr(REG_CTRL, 32'h0000_0004, resp);
    i_fab.op(1'b1, 1'b0, 1'b1, 12'h000, 12'h000, 18'h0000A);
    for (int i = 0; i < 4; i++) begin
      i_fab.op(1'b0, 1'b1, 1'b1, 12'h000, 12'(i), 18'h00000);
      chk(i_fab.last_rd, 32'(i % 2));
    end
    i_fab.jtag(8'h05, 18'h2A5A5);
    axi_wr(REG_CTRL, 32'h0000_0048, resp);
    i_fab.op(1'b0, 1'b1, 1'b1, 12'h000, 12'h005, 18'h00000);
    chk(i_fab.last_rd, 32'h0002_A5A5);
    give_verdict();
  end
endmodule // tb_top
